/* File: core/swb_pkg.sv */
// Package with constants and types for the status word and bank select block.
// What this block does
// - Carry captures add/subtract carry or borrow.
// - Carry ANDs, ORs, XORs with memory bit.
// - Carry set, clear, invert; skip if one.
// - Move carry to memory bit and back.
// - Carry undefined after reset until written.
// - Interrupt pushes whole status word; return pops it.
// - Skip bits updated only by execution.
// - Nesting codes: 00 all, 01 high, 10 none.
// - Acknowledge stacks nesting, then advances it.
// - Nesting bits writable by memory instructions.
// - Expand flag selects bank as address top.
// - Reset loads expand flags from word zero.
// - Vector entry loads both expand flags.
// - Expand flags settable and clearable anytime.
// - Register bank from selector when expanded.
// - Select ops load register or memory bank.
// - Bank word pushed and popped as byte.
// - Memory bank selector 4 bits, 0 or 15.
// - Both bank selectors reset to zero.
// - Status word sits at two data addresses.
// - Calls save and restore only expand flags.
package swb_pkg;
  localparam logic [11:0] SWB_ADDR_LO   = 12'hFB0;
  localparam logic [11:0] SWB_ADDR_HI   = 12'hFB1;
  localparam logic [11:0] SWB_ADDR_SEL  = 12'hF80;
  localparam logic [11:0] SWB_ADDR_MASK = 12'hF00;
  localparam int          SWB_BIT_MBE   = 7;
  localparam int          SWB_BIT_RBE   = 6;
  localparam logic [3:0]  SWB_MBS_RST   = 4'h0;
  localparam logic [1:0]  SWB_RBS_RST   = 2'h0;
  localparam logic [3:0]  SWB_BANK_HI   = 4'hF;
  localparam logic [1:0]  SWB_NEST_ALL  = 2'h0;
  localparam logic [1:0]  SWB_NEST_HIGH = 2'h1;
  localparam logic [1:0]  SWB_NEST_NONE = 2'h2;

  typedef enum logic [3:0] {
    SWB_OP_NONE  = 4'h0,
    SWB_OP_ADD_WITH_CARRY_OP  = 4'h1,
    SWB_OP_SUBTRACT_WITH_BORROW_OP  = 4'h2,
    SWB_OP_SET   = 4'h3,
    SWB_OP_CLR   = 4'h4,
    SWB_OP_INV   = 4'h5,
    SWB_OP_SKT   = 4'h6,
    SWB_OP_MOVTO = 4'h7,
    SWB_OP_MOVFR = 4'h8,
    SWB_OP_AND   = 4'h9,
    SWB_OP_OR    = 4'hA,
    SWB_OP_XOR   = 4'hB
  } swb_carry_op_t;

  typedef struct packed {
    logic       carry_bit;
    logic [2:0] skip_state_bits;
    logic [1:0] nesting_level_bits;
    logic       mem_bank_expand_flag;
    logic       reg_bank_expand_flag;
    logic [3:0] memory_bank_selector;
    logic [1:0] register_bank_selector;
    logic [7:0] rd_data;
    logic       strap_done;
  } swb_state_t;
endpackage

/* File: core/swb_status_bank.sv */
// Status word, carry accumulator and bank selection logic of the core.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module swb_status_bank (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic [7:0]            boot_word_i,
  input  wire swb_pkg::swb_carry_op_t carry_op_i,
  input  wire logic                  alu_carry_i,
  input  wire logic                  mem_bit_i,
  input  wire logic [2:0]            skip_state_i,
  input  wire logic                  skip_state_we_i,
  input  wire logic                  irq_ack_i,
  input  wire logic [7:0]            vector_word_i,
  input  wire logic                  irq_return_i,
  input  wire logic [7:0]            irq_pop_word_i,
  input  wire logic                  call_i,
  input  wire logic                  ret_i,
  input  wire logic [1:0]            ret_flags_i,
  input  wire logic                  choose_reg_bank_i,
  input  wire logic [1:0]            reg_bank_imm_i,
  input  wire logic                  choose_mem_bank_i,
  input  wire logic                  mem_bank_hi_i,
  input  wire logic                  pop_bank_word_i,
  input  wire logic [7:0]            pop_bank_word_data_i,
  input  wire logic [11:0]           addr_i,
  input  wire logic [3:0]            wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  input  wire logic [7:0]            page_addr_i,
  output logic [3:0]                 rdata_o,
  output logic                       carry_bit_o,
  output logic                       mem_bit_o,
  output logic                       skip_next_o,
  output logic [2:0]                 skip_state_o,
  output logic [1:0]                 nesting_level_o,
  output logic [7:0]                 status_push_word_o,
  output logic [1:0]                 call_push_flags_o,
  output logic [7:0]                 bank_select_word_o,
  output logic [11:0]                data_addr_o,
  output logic [1:0]                 active_reg_bank_o
);
  import swb_pkg::*;

  swb_state_t st_reg;
  swb_state_t st_next;
  logic       wr_lo;
  logic       wr_sel;

  assign wr_lo  = wr_i && (addr_i == SWB_ADDR_LO);
  assign wr_sel = wr_i && (addr_i == SWB_ADDR_SEL);

  always_comb begin
    st_next = st_reg;
    st_next.rd_data = 8'h00;
    // Strap loads one cycle after reset release, from the boot word port.
    if (!st_reg.strap_done) begin
      st_next.strap_done = 1'b1;
      st_next.mem_bank_expand_flag = boot_word_i[SWB_BIT_MBE];
      st_next.reg_bank_expand_flag = boot_word_i[SWB_BIT_RBE];
    end
    unique case (carry_op_i)
      SWB_OP_ADD_WITH_CARRY_OP, SWB_OP_SUBTRACT_WITH_BORROW_OP: st_next.carry_bit = alu_carry_i;
      SWB_OP_SET:   st_next.carry_bit = 1'b1;
      SWB_OP_CLR:   st_next.carry_bit = 1'b0;
      SWB_OP_INV:   st_next.carry_bit = ~st_reg.carry_bit;
      SWB_OP_MOVFR: st_next.carry_bit = mem_bit_i;
      SWB_OP_AND:   st_next.carry_bit = st_reg.carry_bit & mem_bit_i;
      SWB_OP_OR:    st_next.carry_bit = st_reg.carry_bit | mem_bit_i;
      SWB_OP_XOR:   st_next.carry_bit = st_reg.carry_bit ^ mem_bit_i;
      default:      st_next.carry_bit = st_reg.carry_bit;
    endcase
    // Skip bits come only from the execution unit, never from the data bus.
    if (skip_state_we_i) begin
      st_next.skip_state_bits = skip_state_i;
    end
    // Four bits at the low status address: nesting level and expand flags.
    if (wr_lo) begin
      st_next.nesting_level_bits = wdata_i[3:2];
      st_next.mem_bank_expand_flag = wdata_i[1];
      st_next.reg_bank_expand_flag = wdata_i[0];
    end
    if (wr_sel) begin
      st_next.register_bank_selector = wdata_i[1:0];
    end
    if (choose_reg_bank_i) begin
      st_next.register_bank_selector = reg_bank_imm_i;
    end
    if (choose_mem_bank_i) begin
      st_next.memory_bank_selector = mem_bank_hi_i ? SWB_BANK_HI : SWB_MBS_RST;
    end
    if (pop_bank_word_i) begin
      // Values other than 0 and 15 fold by the top bit: 8 to 14 onto bank 15, 1 to 7 onto bank 0.
      st_next.memory_bank_selector = pop_bank_word_data_i[7] ? SWB_BANK_HI : SWB_MBS_RST;
      st_next.register_bank_selector = pop_bank_word_data_i[1:0];
    end
    if (ret_i) begin
      st_next.mem_bank_expand_flag = ret_flags_i[1];
      st_next.reg_bank_expand_flag = ret_flags_i[0];
    end
    if (irq_return_i) begin
      st_next.carry_bit = irq_pop_word_i[7];
      st_next.skip_state_bits = irq_pop_word_i[6:4];
      st_next.nesting_level_bits = irq_pop_word_i[3:2];
      st_next.mem_bank_expand_flag = irq_pop_word_i[1];
      st_next.reg_bank_expand_flag = irq_pop_word_i[0];
    end
    // Acknowledge has priority; the pushed word is taken before this edge.
    if (irq_ack_i) begin
      unique case (st_reg.nesting_level_bits)
        SWB_NEST_ALL:  st_next.nesting_level_bits = SWB_NEST_HIGH;
        SWB_NEST_HIGH: st_next.nesting_level_bits = SWB_NEST_NONE;
        default:       st_next.nesting_level_bits = st_reg.nesting_level_bits;
      endcase
      st_next.mem_bank_expand_flag = vector_word_i[SWB_BIT_MBE];
      st_next.reg_bank_expand_flag = vector_word_i[SWB_BIT_RBE];
    end
    if (rd_i) begin
      unique case (addr_i)
        SWB_ADDR_LO:  st_next.rd_data = {4'h0, st_reg.nesting_level_bits,
                                         st_reg.mem_bank_expand_flag,
                                         st_reg.reg_bank_expand_flag};
        SWB_ADDR_HI:  st_next.rd_data = {4'h0, st_reg.carry_bit,
                                         st_reg.skip_state_bits};
        SWB_ADDR_SEL: st_next.rd_data = {4'h0, 2'h0, st_reg.register_bank_selector};
        default:      st_next.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      // Carry has no reset; software must write it before use.
      st_reg.carry_bit <= st_next.carry_bit;
      st_reg.memory_bank_selector <= SWB_MBS_RST;
      st_reg.register_bank_selector <= SWB_RBS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o            = st_reg.rd_data[3:0];
  assign carry_bit_o        = st_reg.carry_bit;
  assign mem_bit_o          = st_reg.carry_bit;
  assign skip_next_o        = (carry_op_i == SWB_OP_SKT) && st_reg.carry_bit;
  assign skip_state_o       = st_reg.skip_state_bits;
  assign nesting_level_o    = st_reg.nesting_level_bits;
  assign status_push_word_o = {st_reg.carry_bit, st_reg.skip_state_bits,
                               st_reg.nesting_level_bits, st_reg.mem_bank_expand_flag,
                               st_reg.reg_bank_expand_flag};
  assign call_push_flags_o  = {st_reg.mem_bank_expand_flag,
                               st_reg.reg_bank_expand_flag};
  assign bank_select_word_o = {st_reg.memory_bank_selector, 2'h0,
                               st_reg.register_bank_selector};
  assign data_addr_o = st_reg.mem_bank_expand_flag ?
                       {st_reg.memory_bank_selector, page_addr_i} :
                       {page_addr_i[7] ? SWB_BANK_HI : SWB_MBS_RST, page_addr_i};
  assign active_reg_bank_o = st_reg.reg_bank_expand_flag ?
                             st_reg.register_bank_selector : 2'h0;

  bank_sel_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (data_addr_o[11:8] == SWB_BANK_HI) || (data_addr_o[11:8] == SWB_MBS_RST))
    else $error("memory bank outside 0 and 15");
  reg_bank_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !st_reg.reg_bank_expand_flag |-> active_reg_bank_o == 2'h0)
    else $error("register bank not fixed to zero");
  nest_adv_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    irq_ack_i && st_reg.strap_done && nesting_level_o == SWB_NEST_ALL
    |=> nesting_level_o == SWB_NEST_HIGH)
    else $error("nesting level did not advance");
  carry_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    carry_op_i == SWB_OP_SET && !irq_return_i |=> carry_bit_o)
    else $error("carry not set");
  carry_and_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    carry_op_i == SWB_OP_AND && !irq_return_i
    |=> carry_bit_o == ($past(carry_bit_o) & $past(mem_bit_i)))
    else $error("carry and result wrong");
  pop_bank_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pop_bank_word_i && !choose_reg_bank_i
    |=> bank_select_word_o[1:0] == $past(pop_bank_word_data_i[1:0]))
    else $error("bank word pop lost");
  sel_zero_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    bank_select_word_o[3:2] == 2'h0)
    else $error("selector upper bits nonzero");
  ret_flags_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ret_i && !irq_ack_i && !irq_return_i
    |=> call_push_flags_o == $past(ret_flags_i))
    else $error("return flags not restored");

  // Each carry operation that writes the carry is checked alone; an interrupt return overrides it.
  carry_clr_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    carry_op_i == SWB_OP_CLR && !irq_return_i |=> !carry_bit_o)
    else $error("carry not cleared");
  carry_inv_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    carry_op_i == SWB_OP_INV && !irq_return_i
    |=> carry_bit_o == !$past(carry_bit_o))
    else $error("carry not inverted");
  carry_or_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    carry_op_i == SWB_OP_OR && !irq_return_i
    |=> carry_bit_o == ($past(carry_bit_o) | $past(mem_bit_i)))
    else $error("carry or result wrong");
  carry_xor_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    carry_op_i == SWB_OP_XOR && !irq_return_i
    |=> carry_bit_o == ($past(carry_bit_o) ^ $past(mem_bit_i)))
    else $error("carry xor result wrong");
  carry_alu_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (carry_op_i == SWB_OP_ADD_WITH_CARRY_OP || carry_op_i == SWB_OP_SUBTRACT_WITH_BORROW_OP) && !irq_return_i
    |=> carry_bit_o == $past(alu_carry_i))
    else $error("carry lost alu result");
  carry_move_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    carry_op_i == SWB_OP_MOVFR && !irq_return_i
    |=> carry_bit_o == $past(mem_bit_i))
    else $error("carry lost memory bit");
  skip_load_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    skip_state_we_i && !irq_return_i
    |=> skip_state_o == $past(skip_state_i))
    else $error("skip bits not loaded");
  nest_high_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    irq_ack_i && nesting_level_o == SWB_NEST_HIGH
    |=> nesting_level_o == SWB_NEST_NONE)
    else $error("nesting level did not reach none");
  vec_flags_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    irq_ack_i |=> call_push_flags_o == $past(vector_word_i[7:6]))
    else $error("vector flags not loaded");
  interrupt_return_op_all_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    irq_return_i && !irq_ack_i
    |=> status_push_word_o == $past(irq_pop_word_i))
    else $error("status word not restored");
  mem_sel_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    choose_mem_bank_i && !pop_bank_word_i
    |=> bank_select_word_o[7:4] == ($past(mem_bank_hi_i) ? SWB_BANK_HI : SWB_MBS_RST))
    else $error("memory bank select lost");
  rd_idle_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !rd_i |=> rdata_o == 4'h0)
    else $error("read data without read");
  // The strap load must win unless a later-priority source writes the flags.
  strap_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !st_reg.strap_done && !irq_ack_i && !wr_lo && !ret_i && !irq_return_i
    |=> call_push_flags_o == $past(boot_word_i[7:6]))
    else $error("boot flags not loaded");
endmodule

/* File: sim/swb_stack_model.sv */
// Stack memory model of the execution unit that saves and restores status and bank words.
`timescale 1ns/1ps
module swb_stack_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       push_status_i,
  input  wire logic [7:0] status_word_i,
  input  wire logic       push_flags_i,
  input  wire logic [1:0] flags_i,
  input  wire logic       push_bank_i,
  input  wire logic [7:0] bank_word_i,
  input  wire logic       pop_i,
  output logic      [7:0] top_o
);
  logic [7:0] mem [0:7];
  logic [2:0] sp_reg;

  // One shared stack, so a return always gets the word of the most recent save.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sp_reg <= 3'h0;
    end else if (push_status_i) begin
      mem[sp_reg] <= status_word_i;
      sp_reg <= sp_reg + 3'h1;
    end else if (push_flags_i) begin
      mem[sp_reg] <= {6'h00, flags_i};
      sp_reg <= sp_reg + 3'h1;
    end else if (push_bank_i) begin
      mem[sp_reg] <= bank_word_i;
      sp_reg <= sp_reg + 3'h1;
    end else if (pop_i) begin
      sp_reg <= sp_reg - 3'h1;
    end
  end

  assign top_o = mem[sp_reg - 3'h1];
endmodule

/* File: sim/tb.sv */
// Self-checking testbench of the status word and bank select block.
`timescale 1ns/1ps
module tb;
  import swb_pkg::*;
  logic core_clk_i = 1'b0, rst_i = 1'b1, alu_carry_i = 1'b0, mem_bit_i = 1'b0;
  logic skip_state_we_i = 1'b0, irq_ack_i = 1'b0, irq_return_i = 1'b0, call_i = 1'b0;
  logic ret_i = 1'b0, choose_reg_bank_i = 1'b0, choose_mem_bank_i = 1'b0, mem_bank_hi_i = 1'b0;
  logic pop_bank_word_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, push_bank = 1'b0;
  logic [7:0] boot_word_i = 8'hC0, vector_word_i = 8'h00, page_addr_i = 8'h5A, top;
  logic [2:0] skip_state_i = 3'h0, skip_state_o;
  logic [1:0] reg_bank_imm_i = 2'h0, nesting_level_o, call_push_flags_o, active_reg_bank_o;
  logic [11:0] addr_i = 12'h000, data_addr_o;
  logic [3:0] wdata_i = 4'h0, rdata_o;
  logic carry_bit_o, mem_bit_o, skip_next_o;
  logic [7:0] status_push_word_o, bank_select_word_o;
  swb_carry_op_t carry_op_i = SWB_OP_NONE;
  int miscompares = 0, comparisons = 0, cycles = 0;
  swb_carry_op_t ops [10] = '{SWB_OP_SET, SWB_OP_CLR, SWB_OP_INV, SWB_OP_AND, SWB_OP_OR,
                              SWB_OP_XOR, SWB_OP_ADD_WITH_CARRY_OP, SWB_OP_SUBTRACT_WITH_BORROW_OP, SWB_OP_MOVFR, SWB_OP_MOVTO};
  logic [9:0] alu_v = 10'b0000001000, mem_v = 10'b0000110010, exp_v = 10'b1010101011;

  swb_status_bank i_swb_status_bank (.core_clk_i, .rst_i, .boot_word_i, .carry_op_i, .alu_carry_i,
    .mem_bit_i, .skip_state_i, .skip_state_we_i, .irq_ack_i, .vector_word_i, .irq_return_i,
    .irq_pop_word_i(top), .call_i, .ret_i, .ret_flags_i(top[1:0]), .choose_reg_bank_i,
    .reg_bank_imm_i, .choose_mem_bank_i, .mem_bank_hi_i, .pop_bank_word_i,
    .pop_bank_word_data_i(top), .addr_i, .wdata_i, .wr_i, .rd_i, .page_addr_i, .rdata_o,
    .carry_bit_o, .mem_bit_o, .skip_next_o, .skip_state_o, .nesting_level_o, .status_push_word_o,
    .call_push_flags_o, .bank_select_word_o, .data_addr_o, .active_reg_bank_o);
  swb_stack_model i_swb_stack_model (.core_clk_i, .rst_i, .push_status_i(irq_ack_i),
    .status_word_i(status_push_word_o), .push_flags_i(call_i), .flags_i(call_push_flags_o),
    .push_bank_i(push_bank), .bank_word_i(bank_select_word_o),
    .pop_i(irq_return_i | ret_i | pop_bank_word_i), .top_o(top));

  always #2.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      miscompares = miscompares + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Ends every pulse at the edge that takes it, then lets that edge's updates land.
  task automatic fin();
    @(posedge core_clk_i);
    {wr_i, rd_i, skip_state_we_i, irq_ack_i, irq_return_i, call_i, ret_i} <= 7'h00;
    {choose_reg_bank_i, choose_mem_bank_i, pop_bank_word_i, push_bank} <= 4'h0;
    carry_op_i <= SWB_OP_NONE;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [3:0] d);
    @(posedge core_clk_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    fin();
  endtask
  task automatic rd(input logic [11:0] a, input logic [3:0] e);
    @(posedge core_clk_i);
    addr_i <= a; rd_i <= 1'b1;
    fin();
    chk("rdata", {8'h00, e}, {8'h00, rdata_o});
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("bank word", 12'h000, {4'h0, bank_select_word_o});
    rd(SWB_ADDR_LO, 4'h3);
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk_i);
      carry_op_i <= ops[i]; alu_carry_i <= alu_v[9-i]; mem_bit_i <= mem_v[9-i];
      fin();
      chk("carry", {11'h000, exp_v[9-i]}, {11'h000, carry_bit_o});
    end
    chk("mem bit", 12'h001, {11'h000, mem_bit_o});
    @(posedge core_clk_i);
    carry_op_i <= SWB_OP_SKT;
    #1 chk("skip", 12'h001, {11'h000, skip_next_o});
    fin();
    wr(SWB_ADDR_LO, 4'h0);
    @(posedge core_clk_i);
    irq_ack_i <= 1'b1; vector_word_i <= 8'h80;
    #1 chk("push word", 12'h080, {4'h0, status_push_word_o});
    fin();
    rd(SWB_ADDR_LO, 4'h6);
    @(posedge core_clk_i);
    carry_op_i <= SWB_OP_CLR; irq_ack_i <= 1'b1; vector_word_i <= 8'h40;
    fin();
    chk("nest", 12'h002, {10'h000, nesting_level_o});
    rd(SWB_ADDR_LO, 4'h9);
    @(posedge core_clk_i); irq_return_i <= 1'b1; fin();
    rd(SWB_ADDR_LO, 4'h6);
    @(posedge core_clk_i); irq_return_i <= 1'b1; fin();
    rd(SWB_ADDR_HI, 4'h8);
    @(posedge core_clk_i); skip_state_we_i <= 1'b1; skip_state_i <= 3'h5; fin();
    chk("skip bits", 12'h005, {9'h000, skip_state_o});
    wr(SWB_ADDR_HI, 4'h0);
    rd(SWB_ADDR_HI, 4'hD);
    rd(12'h123, 4'h0);
    wr(SWB_ADDR_SEL, 4'hF);
    rd(SWB_ADDR_SEL, 4'h3);
    wr(SWB_ADDR_LO, 4'h1);
    chk("reg bank", 12'h003, {10'h000, active_reg_bank_o});
    @(posedge core_clk_i); choose_mem_bank_i <= 1'b1; mem_bank_hi_i <= 1'b1; fin();
    chk("bank word", 12'h0F3, {4'h0, bank_select_word_o});
    @(posedge core_clk_i); choose_reg_bank_i <= 1'b1; reg_bank_imm_i <= 2'h2; fin();
    wr(SWB_ADDR_LO, 4'h3);
    chk("data addr", 12'hF5A, data_addr_o);
    @(posedge core_clk_i); push_bank <= 1'b1; call_i <= 1'b0; fin();
    @(posedge core_clk_i); choose_mem_bank_i <= 1'b1; mem_bank_hi_i <= 1'b0; fin();
    chk("bank word", 12'h002, {4'h0, bank_select_word_o});
    @(posedge core_clk_i); pop_bank_word_i <= 1'b1; fin();
    chk("bank word", 12'h0F2, {4'h0, bank_select_word_o});
    @(posedge core_clk_i); call_i <= 1'b1; fin();
    wr(SWB_ADDR_LO, 4'h4);
    chk("reg bank", 12'h000, {10'h000, active_reg_bank_o});
    chk("data addr", 12'h05A, data_addr_o);
    @(posedge core_clk_i); ret_i <= 1'b1; fin();
    rd(SWB_ADDR_LO, 4'h7);
    tally_and_finish();
  end
endmodule
